/* File: tslr_pkg.sv */
package tslr_pkg;
   localparam int          TSLR_AW            = 16;
   localparam int          TSLR_DW            = 8;
   localparam logic [15:0] TSLR_OFS_STRAP     = 16'h0008;
   localparam logic [15:0] TSLR_OFS_LINE      = 16'h0009;
   localparam logic [15:0] TSLR_OFS_RXLINECLK = 16'h000a;
   localparam logic [15:0] TSLR_OFS_OVH       = 16'h000b;
   localparam logic [15:0] TSLR_OFS_TXSERIAL  = 16'h000c;
   localparam logic [15:0] TSLR_OFS_FRMCLK    = 16'h000d;
   localparam logic [7:0]  TSLR_RST_STRAP     = 8'h08;
   localparam logic [7:0]  TSLR_RST_LINE      = 8'h08;
   localparam logic [7:0]  TSLR_RST_RXLINECLK = 8'h00;
   localparam logic [7:0]  TSLR_RST_OVH       = 8'h00;
   localparam logic [7:0]  TSLR_RST_TXSERIAL  = 8'h00;
   localparam logic [7:0]  TSLR_RST_FRMCLK    = 8'h00;
   localparam logic [7:0]  TSLR_USED_NIBBLE   = 8'h0f;
   localparam int          TSLR_BIT_CPOL      = 7;
   localparam int          TSLR_BIT_CPHA      = 6;
   localparam int          TSLR_BIT_SWAP      = 5;
   localparam int          TSLR_BIT_SERIAL    = 4;
   localparam int          TSLR_BIT_FLOAT_N   = 3;
   localparam int          TSLR_BIT_WIDTH     = 2;
   localparam int          TSLR_BIT_STROBE    = 1;
   localparam int          TSLR_BIT_MUXED     = 0;
   // source selector codes
   localparam logic [3:0]  TSLR_SEL_OFF       = 4'h0;
   localparam logic [3:0]  TSLR_SEL_LOOP      = 4'h1;
   localparam logic [3:0]  TSLR_SEL_ALT       = 4'h2;
   localparam logic [3:0]  TSLR_SEL_E3        = 4'h3;
   localparam logic [3:0]  TSLR_SEL_STS1      = 4'h4;
   localparam logic [3:0]  TSLR_SEL_COAX      = 4'h5;
   localparam logic [3:0]  TSLR_SEL_ZERO      = 4'h6;
   localparam logic [3:0]  TSLR_SEL_ONE       = 4'h7;
endpackage

/* File: tslr_ctrl.sv */
// Operation
// - bits 7..5 serial straps, serial mode only
// - bit 3 low floats transceiver outputs
// - test-port reset low also floats outputs
// - bit 2 selects 8 or 16 bit bus
// - bit 0 muxed; nonmuxed holds latch-enable high
// - line low nibble routes positive rail
// - line high nibble routes negative rail
// - clock register routes receive line clock
// - upper nibbles of two registers unused
// - overhead high nibble routes overhead enable
// - overhead low nibble routes overhead data
// - serial register routes transmit serial data
// - frame register high nibble routes frame start
// - frame register low nibble routes transmit clock
// - disable input floats all transceiver lines
`timescale 1ns/1ps
module tslr_ctrl
   import tslr_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                srst,
   // microcontroller memory bus, same clock
   input  wire logic [TSLR_AW-1:0]  bus_addr,
   input  wire logic                bus_cs,
   input  wire logic                bus_wr,
   input  wire logic                bus_rd,
   input  wire logic [TSLR_DW-1:0]  bus_wdata,
   output logic      [TSLR_DW-1:0]  bus_rdata,
   // board pins, asynchronous
   input  wire logic                board_enable_pin,
   input  wire logic                test_port_reset_n_pin,
   // oscillators and loopback sources
   input  wire logic                osc_t3,
   input  wire logic                osc_e3,
   input  wire logic                osc_sts1,
   input  wire logic                coaxial_input,
   input  wire logic                transmit_positive_rail,
   input  wire logic                transmit_negative_rail,
   input  wire logic                transmit_line_clock,
   input  wire logic                transmit_overhead_frame_start,
   input  wire logic                receive_overhead_frame_start,
   input  wire logic                receive_overhead_data,
   input  wire logic                receive_serial_data,
   input  wire logic                transmit_frame_start_output,
   input  wire logic                receive_frame_start_output,
   input  wire logic                transmit_clock_output,
   input  wire logic                receive_clock_output,
   // straps toward the transceiver
   output logic                     serial_clock_polarity_strap,
   output logic                     serial_clock_phase_strap,
   output logic                     byte_swap_strap,
   output logic                     straps_data_oe,
   output logic                     serial_host_strap,
   output logic                     output_float_n_strap,
   output logic                     bus_width_strap,
   output logic                     strobe_style_strap,
   output logic                     address_latch_enable,
   output logic                     address_latch_enable_oe,
   output logic                     straps_oe,
   output logic                     transceiver_outputs_float,
   // routed lines, each with output enable
   output logic                     receive_positive_rail,
   output logic                     receive_positive_rail_oe,
   output logic                     receive_negative_rail,
   output logic                     receive_negative_rail_oe,
   output logic                     receive_line_clock,
   output logic                     receive_line_clock_oe,
   output logic                     transmit_overhead_enable,
   output logic                     transmit_overhead_enable_oe,
   output logic                     transmit_overhead_data,
   output logic                     transmit_overhead_data_oe,
   output logic                     transmit_serial_data,
   output logic                     transmit_serial_data_oe,
   output logic                     transmit_frame_start_input,
   output logic                     transmit_frame_start_input_oe,
   output logic                     transmit_clock_input,
   output logic                     transmit_clock_input_oe
);

   localparam int NSRC = 8;
   localparam int NLINE = 8;

   // readback and route tables assume one byte lane
   if (TSLR_DW != 8 || TSLR_AW < 4)
   begin : g_bad_width
      $error("tslr_ctrl: bus widths unsupported");
   end

   logic [7:0] strap_control_r;
   logic [7:0] line_input_route_r;
   logic [7:0] receive_line_clock_route_r;
   logic [7:0] overhead_route_r;
   logic [7:0] transmit_serial_route_r;
   logic [7:0] frame_and_clock_route_r;

   logic       en_meta_r;
   logic       en_sync_r;
   logic       jrst_meta_r;
   logic       jrst_sync_r;

   // pins pass two flops before use
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         en_meta_r <= 1'b0;
         en_sync_r <= 1'b0;
      end
      else
      begin
         en_meta_r <= board_enable_pin;
         en_sync_r <= en_meta_r;
      end
   end

   // test-port reset idles high, so this synchronizer floats nothing on leaving our own reset
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         jrst_meta_r <= 1'b1;
         jrst_sync_r <= 1'b1;
      end
      else
      begin
         jrst_meta_r <= test_port_reset_n_pin;
         jrst_sync_r <= jrst_meta_r;
      end
   end

   // register writes; base offset zero in user space
   wire wr_hit = bus_cs && bus_wr;

   always_ff @(posedge clk)
   begin
      if (srst)
         strap_control_r <= TSLR_RST_STRAP;
      else if (wr_hit && bus_addr == TSLR_OFS_STRAP)
         strap_control_r <= bus_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         line_input_route_r <= TSLR_RST_LINE;
      else if (wr_hit && bus_addr == TSLR_OFS_LINE)
         line_input_route_r <= bus_wdata;
   end

   // unused upper nibble is never stored, so it reads back as zero
   always_ff @(posedge clk)
   begin
      if (srst)
         receive_line_clock_route_r <= TSLR_RST_RXLINECLK;
      else if (wr_hit && bus_addr == TSLR_OFS_RXLINECLK)
         receive_line_clock_route_r <= bus_wdata & TSLR_USED_NIBBLE;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         overhead_route_r <= TSLR_RST_OVH;
      else if (wr_hit && bus_addr == TSLR_OFS_OVH)
         overhead_route_r <= bus_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         transmit_serial_route_r <= TSLR_RST_TXSERIAL;
      else if (wr_hit && bus_addr == TSLR_OFS_TXSERIAL)
         transmit_serial_route_r <= bus_wdata & TSLR_USED_NIBBLE;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         frame_and_clock_route_r <= TSLR_RST_FRMCLK;
      else if (wr_hit && bus_addr == TSLR_OFS_FRMCLK)
         frame_and_clock_route_r <= bus_wdata;
   end

   // registered readback, unmapped reads as zero
   always_ff @(posedge clk)
   begin
      if (srst)
         bus_rdata <= 8'h00;
      else if (bus_cs && bus_rd)
      begin
         unique case (bus_addr)
            TSLR_OFS_STRAP:  bus_rdata <= strap_control_r;
            TSLR_OFS_LINE:   bus_rdata <= line_input_route_r;
            TSLR_OFS_RXLINECLK: bus_rdata <= receive_line_clock_route_r;
            TSLR_OFS_OVH:    bus_rdata <= overhead_route_r;
            TSLR_OFS_TXSERIAL: bus_rdata <= transmit_serial_route_r;
            TSLR_OFS_FRMCLK: bus_rdata <= frame_and_clock_route_r;
            default:         bus_rdata <= 8'h00;
         endcase
      end
   end

   // source tables: index = selector code 0..7, 8+ is high impedance
   logic [NSRC-1:0] src_tab [NLINE];
   logic [NSRC-1:0] use_tab [NLINE];
   logic [3:0]      sel     [NLINE];

   always_comb
   begin
      sel[0] = line_input_route_r[3:0];
      sel[1] = line_input_route_r[7:4];
      sel[2] = receive_line_clock_route_r[3:0];
      sel[3] = overhead_route_r[7:4];
      sel[4] = overhead_route_r[3:0];
      sel[5] = transmit_serial_route_r[3:0];
      sel[6] = frame_and_clock_route_r[7:4];
      sel[7] = frame_and_clock_route_r[3:0];
      // bit order: 7=one 6=zero 5=coax 4=sts1 3=e3 2=alt/t3 1=loop 0=off
      src_tab[0] = {2'b10, coaxial_input, osc_sts1, osc_e3, osc_t3, transmit_positive_rail, 1'b0};
      src_tab[1] = {2'b10, coaxial_input, osc_sts1, osc_e3, osc_t3, transmit_negative_rail, 1'b0};
      src_tab[2] = {2'b10, coaxial_input, osc_sts1, osc_e3, osc_t3, transmit_line_clock, 1'b0};
      src_tab[3] = {2'b10, 3'b000, receive_overhead_frame_start, transmit_overhead_frame_start, 1'b0};
      src_tab[4] = {2'b10, 4'b0000, receive_overhead_data, 1'b0};
      src_tab[5] = {2'b10, 4'b0000, receive_serial_data, 1'b0};
      src_tab[6] = {2'b10, 3'b000, receive_frame_start_output, transmit_frame_start_output, 1'b0};
      src_tab[7] = {2'b10, 3'b000, receive_clock_output, transmit_clock_output, 1'b0};
      // unused codes drive nothing
      use_tab[0] = 8'hfe;
      use_tab[1] = 8'hfe;
      use_tab[2] = 8'hfe;
      use_tab[3] = 8'hc6;
      use_tab[4] = 8'hc2;
      use_tab[5] = 8'hc2;
      use_tab[6] = 8'hc6;
      use_tab[7] = 8'hc6;
   end

   logic [NLINE-1:0] line_r;
   logic [NLINE-1:0] line_oe_r;

   // disabled board floats every line toward the transceiver
   genvar gi;
   generate
      for (gi = 0; gi < NLINE; gi++)
      begin : g_route
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               line_r[gi]    <= 1'b0;
               line_oe_r[gi] <= 1'b0;
            end
            else
            begin
               line_r[gi]    <= sel[gi][3] ? 1'b0 : src_tab[gi][sel[gi][2:0]];
               line_oe_r[gi] <= en_sync_r && !sel[gi][3] && use_tab[gi][sel[gi][2:0]];
            end
         end
      end
   endgenerate

   assign receive_positive_rail         = line_r[0];
   assign receive_positive_rail_oe      = line_oe_r[0];
   assign receive_negative_rail         = line_r[1];
   assign receive_negative_rail_oe      = line_oe_r[1];
   assign receive_line_clock            = line_r[2];
   assign receive_line_clock_oe         = line_oe_r[2];
   assign transmit_overhead_enable      = line_r[3];
   assign transmit_overhead_enable_oe   = line_oe_r[3];
   assign transmit_overhead_data        = line_r[4];
   assign transmit_overhead_data_oe     = line_oe_r[4];
   assign transmit_serial_data          = line_r[5];
   assign transmit_serial_data_oe       = line_oe_r[5];
   assign transmit_frame_start_input    = line_r[6];
   assign transmit_frame_start_input_oe = line_oe_r[6];
   assign transmit_clock_input          = line_r[7];
   assign transmit_clock_input_oe       = line_oe_r[7];

   // serial straps share data pins; drive them only in serial host mode
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         serial_clock_polarity_strap <= 1'b0;
         serial_clock_phase_strap    <= 1'b0;
         byte_swap_strap             <= 1'b0;
         straps_data_oe              <= 1'b0;
      end
      else
      begin
         serial_clock_polarity_strap <= strap_control_r[TSLR_BIT_CPOL];
         serial_clock_phase_strap    <= strap_control_r[TSLR_BIT_CPHA];
         byte_swap_strap             <= strap_control_r[TSLR_BIT_SWAP];
         straps_data_oe              <= en_sync_r && strap_control_r[TSLR_BIT_SERIAL];
      end
   end

   // host interface mode straps
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         serial_host_strap    <= 1'b0;
         output_float_n_strap <= 1'b1;
         bus_width_strap      <= 1'b0;
         strobe_style_strap   <= 1'b0;
      end
      else
      begin
         serial_host_strap    <= strap_control_r[TSLR_BIT_SERIAL];
         output_float_n_strap <= strap_control_r[TSLR_BIT_FLOAT_N];
         bus_width_strap      <= strap_control_r[TSLR_BIT_WIDTH];
         strobe_style_strap   <= strap_control_r[TSLR_BIT_STROBE];
      end
   end

   // nonmuxed mode holds latch enable high; muxed mode leaves it to the bus
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         address_latch_enable    <= 1'b1;
         address_latch_enable_oe <= 1'b0;
      end
      else
      begin
         address_latch_enable    <= 1'b1;
         address_latch_enable_oe <= en_sync_r && !strap_control_r[TSLR_BIT_MUXED];
      end
   end

   // float follows the test-port reset even with the strap bit high
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         straps_oe                 <= 1'b0;
         transceiver_outputs_float <= 1'b1;
      end
      else
      begin
         straps_oe                 <= en_sync_r;
         transceiver_outputs_float <= !strap_control_r[TSLR_BIT_FLOAT_N] || !jrst_sync_r;
      end
   end

endmodule // tslr_ctrl

/* File: tslr_ctrl_monitor.sv */
`timescale 1ns/1ps
module tslr_ctrl_monitor
   import tslr_pkg::*;
(
   input wire logic               clk,
   input wire logic               srst,
   input wire logic [TSLR_AW-1:0] bus_addr,
   input wire logic               bus_cs,
   input wire logic               bus_rd,
   input wire logic [TSLR_DW-1:0] bus_rdata,
   input wire logic               board_enable_pin,
   input wire logic               test_port_reset_n_pin,
   input wire logic               output_float_n_strap,
   input wire logic               transceiver_outputs_float,
   input wire logic               straps_data_oe,
   input wire logic               serial_host_strap,
   input wire logic               straps_oe,
   input wire logic               address_latch_enable,
   input wire logic               address_latch_enable_oe,
   input wire logic               receive_positive_rail_oe,
   input wire logic               transmit_clock_input_oe
);
   wire logic rd = bus_cs && bus_rd;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_ale_high: assert property (address_latch_enable) else $error("latch enable low");
   a_ale_gate: assert property (address_latch_enable_oe |-> straps_oe) else $error("latch enable oe");
   a_float_combo: assert property (!output_float_n_strap |-> transceiver_outputs_float) else $error("float");
   a_serial_oe: assert property (straps_data_oe |-> serial_host_strap && straps_oe) else $error("data oe");
   a_disable_all: assert property (!board_enable_pin [*4] |=> !straps_oe && !receive_positive_rail_oe
      && !transmit_clock_input_oe) else $error("drives while disabled");
   a_tpr_float: assert property (!test_port_reset_n_pin [*4] |=> transceiver_outputs_float) else $error("tpr");
   a_line_gate: assert property (receive_positive_rail_oe || transmit_clock_input_oe |-> straps_oe)
      else $error("line oe without enable");
   a_rdata_hold: assert property ((!rd) [*2] |=> $stable(bus_rdata)) else $error("rdata moved");
   a_unmapped_zero: assert property (rd && (bus_addr < TSLR_OFS_STRAP || bus_addr > TSLR_OFS_FRMCLK)
      ##1 !rd |=> bus_rdata == 8'h00) else $error("unmapped read");
   a_unused_nibble: assert property (rd && (bus_addr == TSLR_OFS_RXLINECLK || bus_addr == TSLR_OFS_TXSERIAL)
      ##1 !rd |=> bus_rdata[7:4] == 4'h0) else $error("upper nibble");
endmodule // tslr_ctrl_monitor
bind tslr_ctrl tslr_ctrl_monitor tslr_ctrl_monitor_inst (.clk, .srst, .bus_addr, .bus_cs, .bus_rd, .bus_rdata,
   .board_enable_pin, .test_port_reset_n_pin, .output_float_n_strap, .transceiver_outputs_float, .straps_data_oe,
   .serial_host_strap, .straps_oe, .address_latch_enable, .address_latch_enable_oe, .receive_positive_rail_oe,
   .transmit_clock_input_oe);

/* File: tslr_src_model.sv */
`timescale 1ns/1ps
module tslr_src_model
(
   input  wire logic        clk,
   input  wire logic        step,
   output logic      [14:0] src
);
   // sources hold between steps so the one-cycle route delay cannot blur a check
   initial src = 15'h5a3c;
   always @(posedge clk)
      if (step)
         src <= {src[13:0], ~src[14]} ^ 15'h0421;
endmodule // tslr_src_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import tslr_pkg::*;
   typedef struct packed {logic kind; logic [27:0] e; logic [27:0] m;} tslr_note_t;
   logic        clk, srst, bus_cs, bus_wr, bus_rd, en, tpr_n, snap, step, t1, t2;
   logic [15:0] bus_addr, lfsr;
   logic [7:0]  bus_wdata, bus_rdata, v;
   wire  [7:0]  lv, lo;
   logic [14:0] src;
   wire  [11:0] st;
   logic [27:0] e, m;
   logic [1:0]  p;
   int          err_count, checks_done;
   tslr_note_t  q[$];
   tslr_src_model tslr_src_model_inst (.clk(clk), .step(step), .src(src));
   tslr_ctrl tslr_ctrl_inst (.clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_cs(bus_cs), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .board_enable_pin(en),
      .test_port_reset_n_pin(tpr_n), .osc_t3(src[0]), .osc_e3(src[1]), .osc_sts1(src[2]), .coaxial_input(src[3]),
      .transmit_positive_rail(src[4]), .transmit_negative_rail(src[5]), .transmit_line_clock(src[6]),
      .transmit_overhead_frame_start(src[7]), .receive_overhead_frame_start(src[8]), .receive_overhead_data(src[9]),
      .receive_serial_data(src[10]), .transmit_frame_start_output(src[11]), .receive_frame_start_output(src[12]),
      .transmit_clock_output(src[13]), .receive_clock_output(src[14]), .serial_clock_polarity_strap(st[11]),
      .serial_clock_phase_strap(st[10]), .byte_swap_strap(st[9]), .straps_data_oe(st[8]), .serial_host_strap(st[7]),
      .output_float_n_strap(st[6]), .bus_width_strap(st[5]), .strobe_style_strap(st[4]),
      .address_latch_enable(st[3]), .address_latch_enable_oe(st[2]), .straps_oe(st[1]),
      .transceiver_outputs_float(st[0]), .receive_positive_rail(lv[0]), .receive_positive_rail_oe(lo[0]),
      .receive_negative_rail(lv[1]), .receive_negative_rail_oe(lo[1]), .receive_line_clock(lv[2]),
      .receive_line_clock_oe(lo[2]), .transmit_overhead_enable(lv[3]), .transmit_overhead_enable_oe(lo[3]),
      .transmit_overhead_data(lv[4]), .transmit_overhead_data_oe(lo[4]), .transmit_serial_data(lv[5]),
      .transmit_serial_data_oe(lo[5]), .transmit_frame_start_input(lv[6]), .transmit_frame_start_input_oe(lo[6]),
      .transmit_clock_input(lv[7]), .transmit_clock_input_oe(lo[7]));
   function automatic logic [11:0] sx(input logic [7:0] s, input logic tp);
      return {s[7:5], s[4], s[4], s[3], s[2], s[1], 1'b1, ~s[0], 1'b1, ~s[3] | ~tp};
   endfunction
   // {oe, value} of routed line i for selector code c
   function automatic logic [1:0] ln(input int i, input logic [3:0] c);
      logic [7:0] lp;
      logic       a2;
      lp = {src[13], src[11], src[10], src[9], src[7], src[6], src[5], src[4]};
      a2 = (i == 3) ? src[8] : (i == 6) ? src[12] : (i == 7) ? src[14] : src[0];
      if (c == TSLR_SEL_ZERO || c == TSLR_SEL_ONE)
         return {1'b1, c[0]};
      if (c == TSLR_SEL_LOOP)
         return {1'b1, lp[i]};
      if (c == TSLR_SEL_ALT && i != 4 && i != 5)
         return {1'b1, a2};
      if (c >= TSLR_SEL_E3 && c <= TSLR_SEL_COAX && i < 3)
         return {1'b1, src[c-4'h2]};
      return 2'b00;
   endfunction
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      {bus_cs, bus_wr, bus_addr, bus_wdata} = {2'b11, a, d};
      @(negedge clk);
      {bus_cs, bus_wr} = 2'b00;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      @(negedge clk);
      q.push_back('{1'b0, {20'h0, x}, 28'hff});
      {bus_cs, bus_rd, bus_addr} = {2'b11, a};
      @(negedge clk);
      {bus_cs, bus_rd} = 2'b00;
   endtask
   // waits out the two-flop pin sync and the output register
   task automatic look(input logic [27:0] x, input logic [27:0] k);
      repeat (5) @(negedge clk);
      q.push_back('{1'b1, x, k});
      snap = 1'b1;
      @(negedge clk);
      snap = 1'b0;
   endtask
   task automatic results;
      if (q.size() != 0)
         err_count++;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      t1 <= (bus_cs & bus_rd) | snap;
      t2 <= t1;
   end
   always @(negedge clk)
   begin : mon
      tslr_note_t n;
      logic [27:0] o;
      if (t2 === 1'b1 && q.size() > 0)
      begin
         n = q.pop_front();
         o = n.kind ? {lo, lv, st} : {20'h0, bus_rdata};
         checks_done++;
         if ((o & n.m) !== (n.e & n.m))
         begin
            err_count++;
            $display("unexpected %s exp %h seen %h", n.kind ? "pins" : "rdata", n.e & n.m, o & n.m);
         end
      end
   end
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #500000 err_count++;
      results();
   end
   initial
   begin
      {srst, bus_cs, bus_wr, bus_rd, en, tpr_n, snap, step, bus_addr, bus_wdata} = {8'h8c, 16'h0, 8'h0};
      lfsr = 16'heca1;
      repeat (6) @(posedge clk);
      @(negedge clk) srst = 1'b0;
      for (int i = 0; i < 6; i++) rd(TSLR_OFS_STRAP + 16'(i), i < 2 ? 8'h08 : 8'h00);
      look({8'h00, 8'h00, sx(8'h08, 1'b1)}, {8'hff, 8'h00, 12'hfff});
      for (int c = 0; c < 16; c++)
      begin
         step = 1'b1;
         for (int a = 9; a < 14; a++) wr(16'(a), {2{4'(c)}});
         step = 1'b0;
         e = {16'h0, sx(8'h08, 1'b1)};
         m = {8'hff, 8'h00, 12'hfff};
         for (int i = 0; i < 8; i++)
         begin
            p = ln(i, 4'(c));
            {e[20+i], e[12+i], m[12+i]} = {p, p[1]};
         end
         look(e, m);
         rd(TSLR_OFS_RXLINECLK, {4'h0, 4'(c)});
         rd(TSLR_OFS_TXSERIAL, {4'h0, 4'(c)});
         rd(TSLR_OFS_OVH, {2{4'(c)}});
      end
      for (int j = 0; j < 10; j++)
      begin
         lfsr = lfsr_next(lfsr);
         v = (j == 9) ? 8'h18 : lfsr[7:0];
         wr(TSLR_OFS_STRAP, v);
         look({16'h0, sx(v, 1'b1)}, {16'h0, 12'hfff});
         rd(TSLR_OFS_STRAP, v);
      end
      wr(16'h0007, 8'hff);
      rd(16'h0007, 8'h00);
      rd(16'h000e, 8'h00);
      rd(TSLR_OFS_STRAP, 8'h18);
      tpr_n = 1'b0;
      look({16'h0, sx(8'h18, 1'b0)}, {16'h0, 12'hfff});
      tpr_n = 1'b1;
      wr(TSLR_OFS_LINE, 8'h77);
      wr(TSLR_OFS_FRMCLK, 8'h77);
      en = 1'b0;
      look(28'h0, {8'hff, 8'h00, 12'h106});
      en = 1'b1;
      look({8'hc3, 8'hc3, sx(8'h18, 1'b1)}, {8'hff, 8'hc3, 12'hfff});
      repeat (3) @(negedge clk);
      results();
   end
endmodule // tb_top
